// ==== tsr_regs.sv ====
// host-visible register map of a digital temperature sensor
// assumes: a serial framer on clk delivers host bytes as single-cycle strobes,
// and the converter delivers each result as a one-cycle pulse on clk
`include "tsr_map.svh"

module tsr_regs (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // host byte port
  input wire logic xferStart,
  input wire logic wrValid,
  input wire logic [7:0] wrData,
  input wire logic rdReq,
  output logic [7:0] rdData,
  output logic rdValid,
  // converter result
  input wire logic convValid,
  input wire logic [15:0] convData,
  // configuration to the converter and alarm pins
  output logic [1:0] opMode,
  output logic [1:0] faultQueue,
  output logic ctPolarity,
  output logic intPolarity,
  output logic cmpMode,
  output logic res16,
  // alarm and ready state
  output logic lowAlarm,
  output logic highAlarm,
  output logic critAlarm,
  output logic readyN
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  tsr_pkg::tsr_byte_t ptr_r;
  tsr_pkg::tsr_phase_e phase_r;
  tsr_pkg::tsr_byte_t cfg_r;
  tsr_pkg::tsr_byte_t upperHi_r;
  tsr_pkg::tsr_byte_t upperLo_r;
  tsr_pkg::tsr_byte_t lowerHi_r;
  tsr_pkg::tsr_byte_t lowerLo_r;
  tsr_pkg::tsr_byte_t critHi_r;
  tsr_pkg::tsr_byte_t critLo_r;
  tsr_pkg::tsr_byte_t hyst_r;
  tsr_pkg::tsr_word_t temp_r;
  logic lowFlag_r;
  logic highFlag_r;
  logic critFlag_r;
  logic statLow_r;
  logic statHigh_r;
  logic statCrit_r;
  logic rdyN_r;
  tsr_pkg::tsr_byte_t rdData_r;
  logic rdValid_r;

  logic ptrWr;
  logic dataWr;
  logic softRst;
  logic cfgWr;
  logic statusRead;
  logic tempRead;
  logic rdyRestore;
  tsr_pkg::tsr_opmode_e newMode;
  tsr_pkg::tsr_byte_t rdMux;

  tsr_cmp_if cmp ();

  // ---------------------------------------------------------------
  // limit comparator on each incoming result
  // ---------------------------------------------------------------
  assign cmp.sample = convData;
  assign cmp.upper = {upperHi_r, upperLo_r};
  assign cmp.lower = {lowerHi_r, lowerLo_r};
  assign cmp.crit = {critHi_r, critLo_r};
  assign cmp.hyst = hyst_r;
  assign cmp.res16 = cfg_r[`TSR_CFG_RES16];

  tsr_limit_cmp uCmp (
    .cmp(cmp)
  );

  // ---------------------------------------------------------------
  // host access decode
  // ---------------------------------------------------------------
  // first byte of a write transaction is the pointer
  assign ptrWr = wrValid && (phase_r == tsr_pkg::TSR_PH_POINTER);
  assign dataWr = wrValid && (phase_r == tsr_pkg::TSR_PH_DATA);
  assign softRst = dataWr && (ptr_r == `TSR_ADDR_SOFT_RESET);
  assign cfgWr = dataWr && (ptr_r == `TSR_ADDR_CONFIG);
  assign statusRead = rdReq && (ptr_r == `TSR_ADDR_STATUS);
  assign tempRead = rdReq && ((ptr_r == `TSR_ADDR_TEMP_MSB) ||
                              (ptr_r == `TSR_ADDR_TEMP_LSB));
  assign newMode = tsr_pkg::tsr_opmode_e'(wrData[`TSR_CFG_OPMODE_LSB +: 2]);
  // ready goes back to not-ready on a temperature read or a one-shot or one-SPS mode write
  assign rdyRestore = tempRead ||
                      (cfgWr && ((newMode == tsr_pkg::TSR_MODE_ONESHOT) ||
                                 (newMode == tsr_pkg::TSR_MODE_ONESPS)));

  // ---------------------------------------------------------------
  // transaction phase and address pointer
  // ---------------------------------------------------------------
  // phase returns to pointer at every transaction start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_r <= tsr_pkg::TSR_PH_POINTER;
    end else if (xferStart) begin
      phase_r <= tsr_pkg::TSR_PH_POINTER;
    end else if (ptrWr) begin
      phase_r <= tsr_pkg::TSR_PH_DATA;
    end
  end

  // pointer load, soft reset and high-to-low byte advance
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_r <= `TSR_RST_POINTER;
    end else if (softRst) begin
      ptr_r <= `TSR_RST_POINTER;
    end else if (ptrWr) begin
      ptr_r <= wrData;
    end else if (rdReq && (ptr_r == `TSR_ADDR_TEMP_MSB)) begin
      ptr_r <= `TSR_ADDR_TEMP_LSB;
    end
  end

  // ---------------------------------------------------------------
  // writable registers
  // ---------------------------------------------------------------
  // configuration, limits and hysteresis; read-only offsets are not decoded here
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= `TSR_RST_CONFIG;
      upperHi_r <= `TSR_RST_UPPER_MSB;
      upperLo_r <= `TSR_RST_UPPER_LSB;
      lowerHi_r <= `TSR_RST_LOWER_MSB;
      lowerLo_r <= `TSR_RST_LOWER_LSB;
      critHi_r <= `TSR_RST_CRIT_MSB;
      critLo_r <= `TSR_RST_CRIT_LSB;
      hyst_r <= `TSR_RST_HYST;
    end else if (softRst) begin
      cfg_r <= `TSR_RST_CONFIG;
      upperHi_r <= `TSR_RST_UPPER_MSB;
      upperLo_r <= `TSR_RST_UPPER_LSB;
      lowerHi_r <= `TSR_RST_LOWER_MSB;
      lowerLo_r <= `TSR_RST_LOWER_LSB;
      critHi_r <= `TSR_RST_CRIT_MSB;
      critLo_r <= `TSR_RST_CRIT_LSB;
      hyst_r <= `TSR_RST_HYST;
    end else if (dataWr) begin
      case (ptr_r)
        `TSR_ADDR_CONFIG: begin
          cfg_r <= wrData;
        end
        `TSR_ADDR_UPPER_MSB: begin
          upperHi_r <= wrData;
        end
        `TSR_ADDR_UPPER_LSB: begin
          upperLo_r <= wrData;
        end
        `TSR_ADDR_LOWER_MSB: begin
          lowerHi_r <= wrData;
        end
        `TSR_ADDR_LOWER_LSB: begin
          lowerLo_r <= wrData;
        end
        `TSR_ADDR_CRIT_MSB: begin
          critHi_r <= wrData;
        end
        `TSR_ADDR_CRIT_LSB: begin
          critLo_r <= wrData;
        end
        `TSR_ADDR_HYST: begin
          hyst_r <= wrData;
        end
        default: begin
          cfg_r <= cfg_r;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // temperature result and its live flag bits
  // ---------------------------------------------------------------
  // result word and level flags are caught together on each conversion
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      temp_r <= `TSR_RST_TEMP;
      lowFlag_r <= 1'b0;
      highFlag_r <= 1'b0;
      critFlag_r <= 1'b0;
    end else if (convValid) begin
      temp_r <= convData;
      lowFlag_r <= cmp.belowLow;
      highFlag_r <= cmp.aboveHigh;
      critFlag_r <= cmp.aboveCrit;
    end
  end

  // ---------------------------------------------------------------
  // sticky alarm flags, a new crossing beats a clear in the same cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      statLow_r <= 1'b0;
    end else if (convValid && cmp.belowLow) begin
      statLow_r <= 1'b1;
    end else if (statusRead || (convValid && cmp.clearLow)) begin
      statLow_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      statHigh_r <= 1'b0;
    end else if (convValid && cmp.aboveHigh) begin
      statHigh_r <= 1'b1;
    end else if (statusRead || (convValid && cmp.clearHigh)) begin
      statHigh_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      statCrit_r <= 1'b0;
    end else if (convValid && cmp.aboveCrit) begin
      statCrit_r <= 1'b1;
    end else if (statusRead || (convValid && cmp.clearCrit)) begin
      statCrit_r <= 1'b0;
    end
  end

  // active-low ready: drops on a new result, a new result wins over restore
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdyN_r <= 1'b1;
    end else if (convValid) begin
      rdyN_r <= 1'b0;
    end else if (rdyRestore) begin
      rdyN_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // read select by pointer
  always_comb begin
    case (ptr_r)
      `TSR_ADDR_TEMP_MSB: rdMux = temp_r[15:8];
      `TSR_ADDR_TEMP_LSB: rdMux = cfg_r[`TSR_CFG_RES16] ? temp_r[7:0] :
                                  {temp_r[7:3], critFlag_r, highFlag_r, lowFlag_r};
      `TSR_ADDR_STATUS: rdMux = {rdyN_r, statCrit_r, statHigh_r, statLow_r, 4'h0};
      `TSR_ADDR_CONFIG: rdMux = cfg_r;
      `TSR_ADDR_UPPER_MSB: rdMux = upperHi_r;
      `TSR_ADDR_UPPER_LSB: rdMux = upperLo_r;
      `TSR_ADDR_LOWER_MSB: rdMux = lowerHi_r;
      `TSR_ADDR_LOWER_LSB: rdMux = lowerLo_r;
      `TSR_ADDR_CRIT_MSB: rdMux = critHi_r;
      `TSR_ADDR_CRIT_LSB: rdMux = critLo_r;
      `TSR_ADDR_HYST: rdMux = hyst_r;
      `TSR_ADDR_IDENT: rdMux = `TSR_IDENT_VALUE;
      default: rdMux = `TSR_READ_FILL;
    endcase
  end

  // read data register and its one-cycle valid
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData_r <= 8'h00;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= rdReq;
      if (rdReq) begin
        rdData_r <= rdMux;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rdData = rdData_r;
  assign rdValid = rdValid_r;
  assign opMode = cfg_r[`TSR_CFG_OPMODE_LSB +: 2];
  assign faultQueue = cfg_r[`TSR_CFG_FAULTQ_LSB +: 2];
  assign ctPolarity = cfg_r[`TSR_CFG_CT_POL];
  assign intPolarity = cfg_r[`TSR_CFG_INT_POL];
  assign cmpMode = cfg_r[`TSR_CFG_CMP_MODE];
  assign res16 = cfg_r[`TSR_CFG_RES16];
  assign lowAlarm = statLow_r;
  assign highAlarm = statHigh_r;
  assign critAlarm = statCrit_r;
  assign readyN = rdyN_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_TEMP_RO: assert property (@(posedge clk) disable iff (!reset_n)
    (dataWr && (ptr_r == `TSR_ADDR_TEMP_MSB) && !convValid) |=> $stable(temp_r))
    else $error("temperature changed on a host write");

  AST_READ_SRST: assert property (@(posedge clk) disable iff (!reset_n)
    (rdReq && (ptr_r == `TSR_ADDR_SOFT_RESET)) |=> (rdValid && rdData == `TSR_READ_FILL))
    else $error("soft reset location read wrong");

  AST_IDENT_READ: assert property (@(posedge clk) disable iff (!reset_n)
    (rdReq && (ptr_r == `TSR_ADDR_IDENT)) |=> (rdValid && rdData == `TSR_IDENT_VALUE))
    else $error("identification read wrong");

  AST_PTR_ADVANCE: assert property (@(posedge clk) disable iff (!reset_n)
    (rdReq && (ptr_r == `TSR_ADDR_TEMP_MSB) && !softRst && !ptrWr)
      |=> (ptr_r == `TSR_ADDR_TEMP_LSB) ##0 (rdData == $past(temp_r[15:8])))
    else $error("pointer did not advance after high byte");

  AST_SRST_DEFAULTS: assert property (@(posedge clk) disable iff (!reset_n)
    softRst |=> (ptr_r == `TSR_RST_POINTER && critLo_r == `TSR_RST_CRIT_LSB &&
                 upperHi_r == `TSR_RST_UPPER_MSB && hyst_r == `TSR_RST_HYST))
    else $error("soft reset left a register off its default");

  AST_FLAG_BITS: assert property (@(posedge clk) disable iff (!reset_n)
    (rdValid_r && ($past(ptr_r) == `TSR_ADDR_TEMP_LSB) && !$past(cfg_r[`TSR_CFG_RES16]))
      |-> (rdData_r[2:0] == {$past(critFlag_r), $past(highFlag_r), $past(lowFlag_r)}))
    else $error("13-bit low byte does not carry alarm flags");

  AST_CRIT_SET: assert property (@(posedge clk) disable iff (!reset_n)
    (convValid && cmp.aboveCrit) |=> (statCrit_r && critFlag_r) [*1] ##1 1'b1)
    else $error("critical crossing not flagged");

  AST_STAT_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
    (statusRead && !convValid) |=> !(statLow_r || statHigh_r || statCrit_r))
    else $error("status read did not clear alarms");

  AST_RDY_DROP: assert property (@(posedge clk) disable iff (!reset_n)
    convValid |=> !readyN)
    else $error("ready did not drop on a new result");

  AST_RDY_RESTORE: assert property (@(posedge clk) disable iff (!reset_n)
    (tempRead && !convValid) |=> readyN)
    else $error("temperature read did not restore ready");

endmodule

// ==== tsr_map.svh ====
// register offsets, field positions and reset values of the sensor register map
// assumes: included by bare name from every file that decodes the map
`ifndef TSR_MAP_SVH
`define TSR_MAP_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define TSR_ADDR_TEMP_MSB 8'h00
`define TSR_ADDR_TEMP_LSB 8'h01
`define TSR_ADDR_STATUS 8'h02
`define TSR_ADDR_CONFIG 8'h03
`define TSR_ADDR_UPPER_MSB 8'h04
`define TSR_ADDR_UPPER_LSB 8'h05
`define TSR_ADDR_LOWER_MSB 8'h06
`define TSR_ADDR_LOWER_LSB 8'h07
`define TSR_ADDR_CRIT_MSB 8'h08
`define TSR_ADDR_CRIT_LSB 8'h09
`define TSR_ADDR_HYST 8'h0A
`define TSR_ADDR_IDENT 8'h0B
`define TSR_ADDR_SOFT_RESET 8'h2F

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define TSR_RST_POINTER 8'h00
`define TSR_RST_CONFIG 8'h00
`define TSR_RST_UPPER_MSB 8'h20
`define TSR_RST_UPPER_LSB 8'h00
`define TSR_RST_LOWER_MSB 8'h05
`define TSR_RST_LOWER_LSB 8'h00
`define TSR_RST_CRIT_MSB 8'h49
`define TSR_RST_CRIT_LSB 8'h80
`define TSR_RST_HYST 8'h05
`define TSR_RST_TEMP 16'h0000
// value is arbitrary
`define TSR_IDENT_VALUE 8'h5A
// answer to the write-only location and to unmapped offsets
`define TSR_READ_FILL 8'h00

// ---------------------------------------------------------------
// configuration and status fields
// ---------------------------------------------------------------
`define TSR_CFG_FAULTQ_LSB 0
`define TSR_CFG_CT_POL 2
`define TSR_CFG_INT_POL 3
`define TSR_CFG_CMP_MODE 4
`define TSR_CFG_OPMODE_LSB 5
`define TSR_CFG_RES16 7
`define TSR_STAT_LOW 4
`define TSR_STAT_HIGH 5
`define TSR_STAT_CRIT 6
`define TSR_STAT_RDY_N 7
// one hysteresis step is one degree, 128 counts of the 16-bit word
`define TSR_HYST_SHIFT 7

`endif

// ==== tsr_pkg.sv ====
// types shared by the sensor register map and its limit comparator
// assumes: nothing beyond a SystemVerilog compiler
package tsr_pkg;

  typedef logic [7:0] tsr_byte_t;
  typedef logic [15:0] tsr_word_t;

  // operation mode field encoding
  typedef enum logic [1:0] {
    TSR_MODE_CONT = 2'h0,
    TSR_MODE_ONESHOT = 2'h1,
    TSR_MODE_ONESPS = 2'h2,
    TSR_MODE_SHUTDOWN = 2'h3
  } tsr_opmode_e;

  // write phase of a host transaction
  typedef enum logic {
    TSR_PH_POINTER,
    TSR_PH_DATA
  } tsr_phase_e;

endpackage

// ==== tsr_cmp_if.sv ====
// signals between the register map and its limit comparator
// assumes: tsr_pkg compiled first
interface tsr_cmp_if;
  tsr_pkg::tsr_word_t sample;
  tsr_pkg::tsr_word_t upper;
  tsr_pkg::tsr_word_t lower;
  tsr_pkg::tsr_word_t crit;
  tsr_pkg::tsr_byte_t hyst;
  logic res16;
  logic belowLow;
  logic aboveHigh;
  logic aboveCrit;
  logic clearLow;
  logic clearHigh;
  logic clearCrit;

  modport eval (
    input sample, upper, lower, crit, hyst, res16,
    output belowLow, aboveHigh, aboveCrit, clearLow, clearHigh, clearCrit
  );
  modport user (
    output sample, upper, lower, crit, hyst, res16,
    input belowLow, aboveHigh, aboveCrit, clearLow, clearHigh, clearCrit
  );
endinterface

// ==== tsr_limit_cmp.sv ====
// combinational compare of a sample against the three limits with hysteresis
// assumes: words are twos complement, low three bits ignored in 13-bit mode
module tsr_limit_cmp (
  tsr_cmp_if.eval cmp
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // widen a word to a signed number, masking flag bits in 13-bit mode
  function automatic logic signed [17:0] toNum(input logic [15:0] w, input logic r16);
    logic [15:0] m;
    m = r16 ? w : {w[15:3], 3'h0};
    toNum = {{2{m[15]}}, m};
  endfunction

  logic signed [17:0] sNum;
  logic signed [17:0] loNum;
  logic signed [17:0] hiNum;
  logic signed [17:0] crNum;
  logic signed [17:0] hyNum;

  // operands
  assign sNum = toNum(cmp.sample, cmp.res16);
  assign loNum = toNum(cmp.lower, cmp.res16);
  assign hiNum = toNum(cmp.upper, cmp.res16);
  assign crNum = toNum(cmp.crit, cmp.res16);
  assign hyNum = {7'h00, cmp.hyst[3:0], 7'h00};

  // limit crossings and return-inside-hysteresis tests
  assign cmp.belowLow = sNum < loNum;
  assign cmp.aboveHigh = sNum > hiNum;
  assign cmp.aboveCrit = sNum > crNum;
  assign cmp.clearLow = sNum >= (loNum + hyNum);
  assign cmp.clearHigh = sNum <= (hiNum - hyNum);
  assign cmp.clearCrit = sNum <= (crNum - hyNum);

endmodule

// ==== tsr_host_model.sv ====
// host-side model of the two-wire bus controller, reduced to byte strobes
// assumes: the register map answers a read one cycle after the request
module tsr_host_model (
  // clock
  input wire logic clk,
  // byte port toward the register map
  output logic xferStart,
  output logic wrValid,
  output logic [7:0] wrData,
  output logic rdReq,
  input wire logic [7:0] rdData,
  input wire logic rdValid
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus at time zero
  initial begin
    xferStart = 1'b0;
    wrValid = 1'b0;
    wrData = 8'h00;
    rdReq = 1'b0;
  end

  // ---------------------------------------------------------------
  // write transaction: pointer byte first, then an optional data byte
  // ---------------------------------------------------------------
  task automatic xfer(input logic [7:0] ptr, input logic [7:0] data, input logic withData);
    @(posedge clk) #1 xferStart = 1'b1;
    @(posedge clk) #1 xferStart = 1'b0;
    wrValid = 1'b1;
    wrData = ptr;
    if (withData) begin
      @(posedge clk) #1 wrData = data;
    end
    @(posedge clk) #1 wrValid = 1'b0;
    wrData = ~wrData; // released lane shows no stale byte
  endtask

  // ---------------------------------------------------------------
  // read of one or two bytes at the current pointer, back to back
  // ---------------------------------------------------------------
  task automatic readBytes(input int n, output logic [15:0] got);
    got = 16'h0000;
    @(posedge clk) #1 rdReq = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk) #1 rdReq = (i + 1 < n);
      got = {got[7:0], (rdValid === 1'b1) ? rdData : 8'hXX};
    end
  endtask
endmodule

// ==== tb_top.sv ====
// self-checking bench for the sensor register map
// assumes: tsr_regs, tsr_host_model and tsr_map.svh in the same folder
`include "tsr_map.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, reset_n, xferStart, wrValid, rdReq, rdValid, convValid;
  logic [7:0] wrData, rdData, cfg;
  logic [15:0] convData, got;
  logic [1:0] opMode, faultQueue;
  logic ctPolarity, intPolarity, cmpMode, res16;
  logic lowAlarm, highAlarm, critAlarm, readyN;
  int compares = 0;
  int mismatches = 0;
  int cycles = 0;
  // rows: write flag, offset, written byte, expected read
  logic [24:0] rows [21] = '{
    {1'b0, 8'h03, 8'h00, 8'h00}, {1'b0, 8'h04, 8'h00, 8'h20}, {1'b0, 8'h05, 8'h00, 8'h00},
    {1'b0, 8'h06, 8'h00, 8'h05}, {1'b0, 8'h07, 8'h00, 8'h00}, {1'b0, 8'h08, 8'h00, 8'h49},
    {1'b0, 8'h09, 8'h00, 8'h80}, {1'b0, 8'h0A, 8'h00, 8'h05},
    {1'b0, 8'h0B, 8'h00, `TSR_IDENT_VALUE}, {1'b0, 8'h02, 8'h00, 8'h80},
    {1'b0, 8'h2F, 8'h00, 8'h00}, {1'b0, 8'h00, 8'h00, 8'h00}, {1'b0, 8'h01, 8'h00, 8'h00},
    {1'b1, 8'h04, 8'h30, 8'h30}, {1'b1, 8'h06, 8'hFB, 8'hFB}, {1'b1, 8'h09, 8'h01, 8'h01},
    {1'b1, 8'h0A, 8'h07, 8'h07}, {1'b1, 8'h00, 8'hFF, 8'h00}, {1'b1, 8'h02, 8'hFF, 8'h80},
    {1'b1, 8'h0B, 8'h00, `TSR_IDENT_VALUE}, {1'b1, 8'h3C, 8'h55, 8'h00}};

  // ---------------------------------------------------------------
  // design, host model, clock
  // ---------------------------------------------------------------
  tsr_regs u_dut (.clk(clk), .reset_n(reset_n), .xferStart(xferStart), .wrValid(wrValid),
    .wrData(wrData), .rdReq(rdReq), .rdData(rdData), .rdValid(rdValid),
    .convValid(convValid), .convData(convData), .opMode(opMode), .faultQueue(faultQueue),
    .ctPolarity(ctPolarity), .intPolarity(intPolarity), .cmpMode(cmpMode), .res16(res16),
    .lowAlarm(lowAlarm), .highAlarm(highAlarm), .critAlarm(critAlarm), .readyN(readyN));
  tsr_host_model u_host (.clk(clk), .xferStart(xferStart), .wrValid(wrValid),
    .wrData(wrData), .rdReq(rdReq), .rdData(rdData), .rdValid(rdValid));

  always #5 clk = ~clk;

  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd(input logic [7:0] a, input int n, input logic [15:0] exp);
    u_host.xfer(a, 8'h00, 1'b0);
    u_host.readBytes(n, got);
    chk($sformatf("read at %h", a), exp, got);
  endtask

  task automatic flags(input logic [3:0] exp);
    chk("readyN crit high low", {12'h000, exp},
      {12'h000, readyN, critAlarm, highAlarm, lowAlarm});
  endtask

  task automatic conv(input logic [15:0] w);
    @(posedge clk) #1 convValid = 1'b1;
    convData = w;
    @(posedge clk) #1 convValid = 1'b0;
    convData = ~w;
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    convValid = 1'b0;
    convData = 16'h0000;
    repeat (10) @(posedge clk);
    #1 reset_n = 1'b1;
    flags(4'h8);
    for (int i = 0; i < 21; i++) begin
      if (rows[i][24]) begin
        u_host.xfer(rows[i][23:16], rows[i][15:8], 1'b1);
      end
      rd(rows[i][23:16], 1, {8'h00, rows[i][7:0]});
    end
    // every operation mode with varied side fields
    for (int m = 0; m < 4; m++) begin
      cfg = {1'b1, 2'(m), 5'h1D - 5'(m)};
      u_host.xfer(8'h03, cfg, 1'b1);
      chk("config pins", {8'h00, cfg}, {8'h00, res16, opMode, cmpMode, intPolarity,
        ctPolarity, faultQueue});
    end
    // soft reset restores pointer, config and limits
    conv(16'h3300);
    u_host.xfer(8'h2F, 8'h00, 1'b1);
    u_host.readBytes(1, got);
    chk("pointer after soft reset", 16'h0033, got);
    rd(8'h04, 1, 16'h0020);
    rd(8'h0A, 1, 16'h0005);
    rd(8'h03, 1, 16'h0000);
    // 13-bit flags, status set and clear
    conv(16'h4A00);
    flags(4'h6);
    rd(8'h00, 2, 16'h4A06);
    flags(4'hE);
    rd(8'h02, 1, 16'h00E0);
    rd(8'h02, 1, 16'h0080);
    conv(16'hFF1F);
    rd(8'h00, 2, 16'hFF19);
    rd(8'h02, 1, 16'h0090);
    // high alarm held inside the hysteresis band, cleared below it
    conv(16'h2100);
    conv(16'h1E00);
    flags(4'h2);
    conv(16'h1D00);
    flags(4'h0);
    // 16-bit result bits and a pointer that stays on the low byte
    u_host.xfer(8'h03, 8'h80, 1'b1);
    conv(16'h1234);
    rd(8'h01, 1, 16'h0034);
    u_host.readBytes(1, got);
    chk("low byte again", 16'h0034, got);
    // mode writes and the ready flag
    conv(16'h1000);
    u_host.xfer(8'h03, 8'hA0, 1'b1);
    flags(4'h8);
    conv(16'h1000);
    u_host.xfer(8'h03, 8'h80, 1'b1);
    flags(4'h0);
    u_host.xfer(8'h03, 8'hC0, 1'b1);
    flags(4'h8);
    stop_test();
  end
endmodule
